//--- shared/isi_pkg.sv
// Package for the I2C slave register interface: register map, field layout,
// reset values, state codes and the packed state records of both design modules.
// Assumes a 32-bit APB slave port with an 8-bit byte address.
`default_nettype none

package isi_pkg;

    localparam int APB_AW = 8;

    // Register byte addresses, one aligned word each.
    localparam logic [7:0] ADDR_DATA  = 8'h00;
    localparam logic [7:0] ADDR_SADDR = 8'h04;
    localparam logic [7:0] ADDR_MODE  = 8'h08;
    localparam logic [7:0] ADDR_STAT  = 8'h0C;

    // Mode control layout.
    localparam int POS_MODE_LO = 5;
    localparam int POS_DEB_LO  = 2;
    localparam int POS_EN      = 1;
    localparam int POS_ICF     = 0;

    // Bus status control layout.
    localparam int POS_HTX  = 4;
    localparam int POS_ACK_TO_SEND = 3;
    localparam int POS_MWE  = 1;

    // Operating mode codes.
    localparam logic [2:0] MODE_SPI_SLAVE = 3'h5;
    localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
    localparam logic [2:0] MODE_UNUSED    = 3'h7;

    // Debounce selections and their lengths in system clocks.
    localparam logic [1:0] DEB_NONE  = 2'h0;
    localparam logic [2:0] DEB_SHORT = 3'h2;
    localparam logic [2:0] DEB_LONG  = 3'h4;

    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_RX       = 3'b011,
        ST_RX_ACK   = 3'b100,
        ST_TX       = 3'b101,
        ST_TX_ACK   = 3'b110,
        ST_HOLD     = 3'b111
    } isi_state_t;

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       level;
        logic [2:0] cnt;
    } isi_filt_t;

    localparam isi_filt_t FILT_RST = '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, cnt: 3'h0};

    typedef struct packed {
        logic [7:0] sdata;
        logic [7:0] saddr;
        logic [2:0] mode;
        logic [1:0] deb;
        logic       en;
        logic       icf;
        logic       byte_done_flag;
        logic       addr_match_flag;
        logic       bus_busy_flag;
        logic       transmit_select;
        logic       ack_to_send;
        logic       master_read_flag;
        logic       mwe;
        logic       ack_received_n;
        isi_state_t state;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic       ack_drive;
        logic       sda_drv;
        logic       scl_hold;
        logic       scl_prev;
        logic       sda_prev;
        logic [7:0] rdata;
        logic       irq;
        logic       en_prev;
    } isi_core_t;

    localparam isi_core_t CORE_RST = '{
        sdata: 8'h00, saddr: 8'h00, mode: MODE_UNUSED, deb: DEB_NONE,
        en: 1'b0, icf: 1'b0, byte_done_flag: 1'b1, addr_match_flag: 1'b0, bus_busy_flag: 1'b0, transmit_select: 1'b0,
        ack_to_send: 1'b0, master_read_flag: 1'b0, mwe: 1'b0, ack_received_n: 1'b1, state: ST_IDLE,
        bitcnt: 3'h0, shreg: 8'h00, ack_drive: 1'b0, sda_drv: 1'b0,
        scl_hold: 1'b0, scl_prev: 1'b1, sda_prev: 1'b1, rdata: 8'h00,
        irq: 1'b0, en_prev: 1'b0
    };

endpackage

`default_nettype wire

//--- logic/isi_line_filter.sv
// Synchroniser and debounce filter for one bus line.
// Assumes an asynchronous pin input; the line idles high.
`default_nettype none

module isi_line_filter (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       pin_in,
    input  wire logic [1:0] debounce_sel,
    output logic            line_out
);

    isi_pkg::isi_filt_t r;
    isi_pkg::isi_filt_t n;
    logic [2:0]         need;

    assign need     = debounce_sel[1] ? isi_pkg::DEB_LONG : isi_pkg::DEB_SHORT;
    assign line_out = r.level;

    // A new level is accepted only after it has stood for the selected number of clocks.
    always_comb begin
        n       = r;
        n.sync1 = pin_in;
        n.sync2 = r.sync1;
        if (r.sync2 == r.level) begin
            n.cnt = 3'h0;
        end else if (debounce_sel == isi_pkg::DEB_NONE) begin
            n.level = r.sync2;
            n.cnt   = 3'h0;
        end else begin
            n.cnt = r.cnt + 3'h1;
            if (n.cnt >= need) begin
                n.level = r.sync2;
                n.cnt   = 3'h0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= isi_pkg::FILT_RST;
        end else begin
            r <= n;
        end
    end

endmodule

`default_nettype wire

//--- logic/isi_slave.sv
// I2C slave-only serial interface with its four software registers on APB.
// Assumes open-drain bus lines resolved outside; the two line inputs are asynchronous.
//
// Contract
// - All data bytes pass the data register; the address byte is only compared, not stored there.
// - Address register holds address in bits 7..1.
// - Matching address selects this slave.
// - Mode field selects function; 110 is I2C.
// - Debounce field filters clock by 0/2/4 clocks.
// - Enable low releases pins, idles interface.
// - Enable rise resets flags, keeps direction/ack bits.
// - Byte-done low while moving, set plus request.
// - Address-match flag follows address comparison.
// - Busy sets on START, clears on STOP.
// - Transmit-select picks sending or receiving bytes.
// - Ack-to-send driven on ninth clock.
// - Read/write flag captures the direction bit.
// - Match-wake enable wakes processor on match.
// - Received-ack flag records master acknowledge.
// - Transmitter releases data line after no-ack.
// - Mode register bit 4 reads zero.
// - START is data falling with clock high.
// - Matching address gets a low acknowledge.
// - Clock held low until data register access.
//
// The implementer's own choices: register access over APB and the register addresses.
`default_nettype none

module isi_slave (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    output logic             irq_req,
    output logic             wake_req
);

    isi_pkg::isi_core_t r;
    isi_pkg::isi_core_t n;

    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic active;
    logic en_rise;
    logic setup_ph;
    logic access_ph;
    logic data_acc;

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == isi_pkg::ADDR_DATA) || (a == isi_pkg::ADDR_SADDR) ||
               (a == isi_pkg::ADDR_MODE) || (a == isi_pkg::ADDR_STAT);
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] a, input isi_pkg::isi_core_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            isi_pkg::ADDR_DATA:  v = s.sdata;
            isi_pkg::ADDR_SADDR: v = s.saddr;
            isi_pkg::ADDR_MODE:  v = {s.mode, 1'b0, s.deb, s.en, s.icf};
            isi_pkg::ADDR_STAT:  v = {s.byte_done_flag, s.addr_match_flag, s.bus_busy_flag, s.transmit_select, s.ack_to_send, s.master_read_flag, s.mwe, s.ack_received_n};
            default:             v = 8'h00;
        endcase
        return v;
    endfunction

    // Both lines see the same filter so START and STOP keep their relative timing.
    isi_line_filter u_scl_filt (
        .core_clk     (core_clk),
        .sys_rst      (sys_rst),
        .pin_in       (scl_in),
        .debounce_sel (r.deb),
        .line_out     (scl_f)
    );

    isi_line_filter u_sda_filt (
        .core_clk     (core_clk),
        .sys_rst      (sys_rst),
        .pin_in       (sda_in),
        .debounce_sel (r.deb),
        .line_out     (sda_f)
    );

    assign active    = r.en && (r.mode == isi_pkg::MODE_I2C_SLAVE);
    assign en_rise   = r.en && !r.en_prev;
    assign scl_rise  = scl_f && !r.scl_prev;
    assign scl_fall  = !scl_f && r.scl_prev;
    assign start_ev  = r.scl_prev && scl_f && r.sda_prev && !sda_f;
    assign stop_ev   = r.scl_prev && scl_f && !r.sda_prev && sda_f;
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign data_acc  = access_ph && (paddr == isi_pkg::ADDR_DATA);

    assign prdata   = {24'h000000, r.rdata};
    assign pready   = access_ph;
    assign pslverr  = access_ph && !addr_mapped(paddr);
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = !(active && r.scl_hold);
    assign sda_oe_n = !(active && r.sda_drv);
    assign irq_req  = r.irq;
    assign wake_req = r.mwe && r.addr_match_flag;

    always_comb begin
        n          = r;
        n.irq      = 1'b0;
        n.en_prev  = r.en;
        n.scl_prev = scl_f;
        n.sda_prev = sda_f;

        // Read data is captured in the setup cycle so that it leaves a flip-flop.
        if (setup_ph) begin
            n.rdata = read_reg(paddr, r);
        end
        if (access_ph && pwrite) begin
            case (paddr)
                isi_pkg::ADDR_DATA:  n.sdata = pwdata[7:0];
                isi_pkg::ADDR_SADDR: n.saddr = pwdata[7:0];
                isi_pkg::ADDR_MODE: begin
                    n.mode = pwdata[isi_pkg::POS_MODE_LO +: 3];
                    n.deb  = pwdata[isi_pkg::POS_DEB_LO +: 2];
                    n.en   = pwdata[isi_pkg::POS_EN];
                    n.icf  = pwdata[isi_pkg::POS_ICF];
                end
                isi_pkg::ADDR_STAT: begin
                    n.transmit_select  = pwdata[isi_pkg::POS_HTX];
                    n.ack_to_send = pwdata[isi_pkg::POS_ACK_TO_SEND];
                    n.mwe  = pwdata[isi_pkg::POS_MWE];
                end
                default: begin
                end
            endcase
        end

        if (!active) begin
            n.state     = isi_pkg::ST_IDLE;
            n.sda_drv   = 1'b0;
            n.scl_hold  = 1'b0;
            n.ack_drive = 1'b0;
        end else if (start_ev) begin
            n.bus_busy_flag      = 1'b1;
            n.byte_done_flag      = 1'b0;
            n.state    = isi_pkg::ST_ADDR;
            n.bitcnt   = 3'h0;
            n.sda_drv  = 1'b0;
            n.scl_hold = 1'b0;
        end else if (stop_ev) begin
            n.bus_busy_flag       = 1'b0;
            n.state     = isi_pkg::ST_IDLE;
            n.sda_drv   = 1'b0;
            n.scl_hold  = 1'b0;
            n.ack_drive = 1'b0;
        end else begin
            case (r.state)
                isi_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        n.shreg  = {r.shreg[6:0], sda_f};
                        n.bitcnt = r.bitcnt + 3'h1;
                        if (r.bitcnt == isi_pkg::BIT_LAST) begin
                            if (n.shreg[7:1] == r.saddr[7:1]) begin
                                n.addr_match_flag      = 1'b1;
                                n.master_read_flag       = sda_f;
                                n.byte_done_flag       = 1'b1;
                                n.irq       = 1'b1;
                                n.ack_drive = 1'b0;
                                n.state     = isi_pkg::ST_ADDR_ACK;
                            end else begin
                                n.addr_match_flag  = 1'b0;
                                n.state = isi_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                isi_pkg::ST_ADDR_ACK, isi_pkg::ST_RX_ACK: begin
                    // First falling edge opens the ninth bit, the second ends it.
                    if (scl_fall) begin
                        if (!r.ack_drive) begin
                            n.ack_drive = 1'b1;
                            n.sda_drv   = (r.state == isi_pkg::ST_ADDR_ACK) ? 1'b1 : !r.ack_to_send;
                        end else begin
                            n.ack_drive = 1'b0;
                            n.sda_drv   = 1'b0;
                            n.scl_hold  = 1'b1;
                            n.state     = isi_pkg::ST_HOLD;
                        end
                    end
                end
                isi_pkg::ST_RX: begin
                    if (scl_rise) begin
                        n.shreg  = {r.shreg[6:0], sda_f};
                        n.bitcnt = r.bitcnt + 3'h1;
                        if (r.bitcnt == isi_pkg::BIT_LAST) begin
                            n.sdata     = n.shreg;
                            n.byte_done_flag       = 1'b1;
                            n.irq       = 1'b1;
                            n.ack_drive = 1'b0;
                            n.state     = isi_pkg::ST_RX_ACK;
                        end
                    end
                end
                isi_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (r.bitcnt == isi_pkg::BIT_LAST) begin
                            n.sda_drv = 1'b0;
                            n.state   = isi_pkg::ST_TX_ACK;
                        end else begin
                            n.shreg   = {r.shreg[6:0], 1'b0};
                            n.sda_drv = !r.shreg[6];
                            n.bitcnt  = r.bitcnt + 3'h1;
                        end
                    end
                end
                isi_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        n.ack_received_n = sda_f;
                        n.byte_done_flag  = 1'b1;
                        n.irq  = 1'b1;
                    end else if (scl_fall) begin
                        if (!r.ack_received_n) begin
                            n.scl_hold = 1'b1;
                            n.state    = isi_pkg::ST_HOLD;
                        end else begin
                            n.state = isi_pkg::ST_IDLE;
                        end
                    end
                end
                isi_pkg::ST_HOLD: begin
                    // Any data register access frees the clock; a write also supplies the next byte.
                    if (data_acc) begin
                        n.scl_hold = 1'b0;
                        n.bitcnt   = 3'h0;
                        n.byte_done_flag      = 1'b0;
                        if (r.transmit_select) begin
                            n.state   = isi_pkg::ST_TX;
                            n.shreg   = n.sdata;
                            n.sda_drv = !n.sdata[7];
                        end else begin
                            n.state = isi_pkg::ST_RX;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (en_rise && (r.mode == isi_pkg::MODE_I2C_SLAVE)) begin
            n.byte_done_flag   = isi_pkg::CORE_RST.byte_done_flag;
            n.addr_match_flag  = isi_pkg::CORE_RST.addr_match_flag;
            n.bus_busy_flag   = isi_pkg::CORE_RST.bus_busy_flag;
            n.master_read_flag   = isi_pkg::CORE_RST.master_read_flag;
            n.ack_received_n  = isi_pkg::CORE_RST.ack_received_n;
            n.irq   = 1'b0;
            n.state = isi_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= isi_pkg::CORE_RST;
        end else begin
            r <= n;
        end
    end

    property p_start_busy;
        @(posedge core_clk) disable iff (sys_rst)
        (active && start_ev && !en_rise) |=> r.bus_busy_flag;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy flag not set by START");

    property p_stop_free;
        @(posedge core_clk) disable iff (sys_rst)
        (active && stop_ev && !start_ev) |=> !r.bus_busy_flag;
    endproperty
    a_stop_free: assert property (p_stop_free) else $error("busy flag not cleared by STOP");

    property p_bit4_zero;
        @(posedge core_clk) disable iff (sys_rst)
        (setup_ph && paddr == isi_pkg::ADDR_MODE) ##1 (access_ph && paddr == isi_pkg::ADDR_MODE) |-> !prdata[4];
    endproperty
    a_bit4_zero: assert property (p_bit4_zero) else $error("mode bit 4 read as one");

    property p_disabled_release;
        @(posedge core_clk) disable iff (sys_rst)
        // The state machine reaches idle one clock after the enable bit falls.
        !r.en |-> (scl_oe_n && sda_oe_n) ##1 (r.state == isi_pkg::ST_IDLE);
    endproperty
    a_disabled_release: assert property (p_disabled_release) else $error("lines driven while disabled");

    property p_enable_rise;
        @(posedge core_clk) disable iff (sys_rst)
        (en_rise && r.mode == isi_pkg::MODE_I2C_SLAVE && !(access_ph && pwrite))
            |=> (r.byte_done_flag && !r.addr_match_flag && !r.bus_busy_flag && !r.master_read_flag && r.ack_received_n && r.transmit_select == $past(r.transmit_select) && r.ack_to_send == $past(r.ack_to_send));
    endproperty
    a_enable_rise: assert property (p_enable_rise) else $error("flags wrong after enable rise");

    property p_done_request;
        @(posedge core_clk) disable iff (sys_rst)
        ($rose(r.byte_done_flag) && !$past(en_rise)) |-> irq_req;
    endproperty
    a_done_request: assert property (p_done_request) else $error("byte done without request");

    property p_match_request;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(r.addr_match_flag) |-> (irq_req && r.state == isi_pkg::ST_ADDR_ACK);
    endproperty
    a_match_request: assert property (p_match_request) else $error("match without request");

    property p_addr_ack_low;
        @(posedge core_clk) disable iff (sys_rst)
        (r.state == isi_pkg::ST_ADDR_ACK && r.ack_drive && active) |-> (!sda_oe_n && r.addr_match_flag);
    endproperty
    a_addr_ack_low: assert property (p_addr_ack_low) else $error("address not acknowledged low");

    property p_hold_clock;
        @(posedge core_clk) disable iff (sys_rst)
        (r.state == isi_pkg::ST_HOLD && active && !data_acc) |=> (!scl_oe_n || !active || start_ev || stop_ev);
    endproperty
    a_hold_clock: assert property (p_hold_clock) else $error("clock released without data access");

    property p_nack_release;
        @(posedge core_clk) disable iff (sys_rst)
        (r.state == isi_pkg::ST_TX_ACK) |-> sda_oe_n;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("data line driven in ack slot");

    c_match: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(r.addr_match_flag));
    c_rx_byte: cover property (@(posedge core_clk) disable iff (sys_rst)
        r.state == isi_pkg::ST_RX ##1 r.state == isi_pkg::ST_RX_ACK);
    c_tx_nack: cover property (@(posedge core_clk) disable iff (sys_rst)
        r.state == isi_pkg::ST_TX_ACK && r.ack_received_n ##1 r.state == isi_pkg::ST_IDLE);

endmodule

`default_nettype wire

//--- tb/isi_i2c_master.sv
// Behavioural I2C bus master that stands on the far side of the slave.
// Assumes the bench resolves both open-drain lines with pull-ups; a low drive pulls a line.
`default_nettype none

module isi_i2c_master (
    input  wire logic core_clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_drv,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 20;
    int n_stall = 0;

    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic hw(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // The slave may stretch the clock, so the high phase starts only once the line is seen high.
    task automatic clk_high();
        int i;
        scl_drv <= 1'b1;
        for (i = 0; i < 3000 && scl !== 1'b1; i++) begin
            @(posedge core_clk);
        end
        if (i == 3000) n_stall++;
        hw(HALF);
    endtask

    // Data changes mid-way through the low phase, never together with a clock edge.
    task automatic bit_slot(input logic b, output logic s);
        hw(HALF / 2);
        sda_drv <= b;
        hw(HALF / 2);
        clk_high();
        s = sda;
        scl_drv <= 1'b0;
    endtask

    task automatic start();
        sda_drv <= 1'b0;
        hw(HALF);
        scl_drv <= 1'b0;
    endtask

    task automatic stop();
        hw(HALF / 2);
        sda_drv <= 1'b0;
        hw(HALF / 2);
        clk_high();
        sda_drv <= 1'b1;
        hw(HALF);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
        bit_slot(1'b1, ack);
    endtask

    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
        bit_slot(ack, s);
    endtask

    // Short low pulse on the data line with the clock high, to probe the debounce.
    task automatic glitch(input int n);
        sda_drv <= 1'b0;
        hw(n);
        sda_drv <= 1'b1;
        hw(HALF);
    endtask
endmodule

`default_nettype wire

//--- tb/isi_slave_tb_top.sv
// Self-checking bench for the I2C slave register interface.
// Assumes the master model drives the bus; pull-ups on both lines are modelled here.
`default_nettype none

module isi_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic [7:0]  paddr    = 8'h00;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, irq_req, wake_req, scl_m, sda_m, a;
    logic [7:0]  b;
    int          n_fail     = 0;
    int          n_compared = 0;
    int          n_irq      = 0;
    wire         scl_w      = scl_m & (scl_oe_n | scl_out);
    wire         sda_w      = sda_m & (sda_oe_n | sda_out);

    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (irq_req === 1'b1) n_irq++;

    isi_slave i_isi_slave (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq_req(irq_req), .wake_req(wake_req));
    isi_i2c_master i_isi_i2c_master (.core_clk(core_clk), .scl(scl_w), .sda(sda_w), .scl_drv(scl_m),
        .sda_drv(sda_m));

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel    <= 1'b1;
        paddr   <= ad;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        a = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            n_fail++;
            finish_test();
        end
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(r, exp);
    endtask

    // The dummy access must not come before the slave stretches the clock.
    task automatic wait_hold();
        int i;
        for (i = 0; i < 200 && scl_oe_n !== 1'b0; i++) @(posedge core_clk);
        chk(32'(scl_oe_n), 32'h0);
        if (i == 200) finish_test();
    endtask

    task automatic setup(input logic [7:0] st, input logic [7:0] md);
        apb(1'b1, isi_pkg::ADDR_MODE, 32'hC0);
        apb(1'b1, isi_pkg::ADDR_SADDR, 32'hA4);
        apb(1'b1, isi_pkg::ADDR_STAT, 32'(st));
        apb(1'b1, isi_pkg::ADDR_MODE, 32'(md));
        n_irq = 0;
    endtask

    task automatic t_regs();
        rdchk(isi_pkg::ADDR_DATA, 32'h00);
        rdchk(isi_pkg::ADDR_SADDR, 32'h00);
        rdchk(isi_pkg::ADDR_MODE, 32'hE0);
        rdchk(isi_pkg::ADDR_STAT, 32'h81);
        apb(1'b1, isi_pkg::ADDR_MODE, 32'hFF);
        rdchk(isi_pkg::ADDR_MODE, 32'hEF);
        apb(1'b1, isi_pkg::ADDR_SADDR, 32'hA5);
        rdchk(isi_pkg::ADDR_SADDR, 32'hA5);
        apb(1'b1, isi_pkg::ADDR_STAT, 32'hFF);
        rdchk(isi_pkg::ADDR_STAT, 32'h9B);
        apb(1'b1, 8'h10, 32'hFF);
        chk(32'(a), 32'h1);
        rdchk(8'h10, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_rx();
        setup(8'h02, 8'hC6);
        i_isi_i2c_master.start();
        rdchk(isi_pkg::ADDR_STAT, 32'h23);
        i_isi_i2c_master.write_byte(8'hA4, a);
        chk(32'(a), 32'h0);
        rdchk(isi_pkg::ADDR_STAT, 32'hE3);
        chk(32'(wake_req), 32'h1);
        chk(32'(n_irq), 32'h1);
        wait_hold();
        rdchk(isi_pkg::ADDR_DATA, 32'h00);
        i_isi_i2c_master.write_byte(8'h36, a);
        chk(32'(a), 32'h0);
        wait_hold();
        rdchk(isi_pkg::ADDR_DATA, 32'h36);
        chk(32'(n_irq), 32'h2);
        apb(1'b1, isi_pkg::ADDR_STAT, 32'h0A);
        i_isi_i2c_master.write_byte(8'h5A, a);
        chk(32'(a), 32'h1);
        wait_hold();
        rdchk(isi_pkg::ADDR_DATA, 32'h5A);
        apb(1'b1, isi_pkg::ADDR_STAT, 32'h00);
        i_isi_i2c_master.stop();
        apb(1'b0, isi_pkg::ADDR_STAT, 32'h0);
        chk(32'(r[5]), 32'h0);
        $display("test rx done");
    endtask

    task automatic t_tx();
        setup(8'h10, 8'hCA);
        i_isi_i2c_master.start();
        i_isi_i2c_master.write_byte(8'hA5, a);
        chk(32'(a), 32'h0);
        rdchk(isi_pkg::ADDR_STAT, 32'hF5);
        wait_hold();
        apb(1'b1, isi_pkg::ADDR_DATA, 32'hC5);
        i_isi_i2c_master.read_byte(1'b0, b);
        chk(32'(b), 32'hC5);
        apb(1'b0, isi_pkg::ADDR_STAT, 32'h0);
        chk(32'(r[0]), 32'h0);
        wait_hold();
        apb(1'b1, isi_pkg::ADDR_DATA, 32'h81);
        i_isi_i2c_master.read_byte(1'b1, b);
        chk(32'(b), 32'h81);
        apb(1'b0, isi_pkg::ADDR_STAT, 32'h0);
        chk(32'(r[0]), 32'h1);
        repeat (20) @(posedge core_clk);
        chk(32'(sda_oe_n), 32'h1);
        chk(32'(scl_oe_n), 32'h1);
        chk(32'(n_irq), 32'h3);
        i_isi_i2c_master.stop();
        $display("test tx done");
    endtask

    task automatic t_other();
        setup(8'h18, 8'hCE);
        i_isi_i2c_master.glitch(2);
        rdchk(isi_pkg::ADDR_STAT, 32'h99);
        i_isi_i2c_master.start();
        i_isi_i2c_master.write_byte(8'h10, a);
        chk(32'(a), 32'h1);
        rdchk(isi_pkg::ADDR_STAT, 32'h39);
        apb(1'b1, isi_pkg::ADDR_MODE, 32'hC0);
        apb(1'b1, isi_pkg::ADDR_MODE, 32'hC2);
        rdchk(isi_pkg::ADDR_STAT, 32'h99);
        i_isi_i2c_master.stop();
        i_isi_i2c_master.glitch(2);
        rdchk(isi_pkg::ADDR_STAT, 32'h19);
        apb(1'b1, isi_pkg::ADDR_MODE, 32'hA2);
        i_isi_i2c_master.start();
        i_isi_i2c_master.write_byte(8'hA4, a);
        chk(32'(a), 32'h1);
        i_isi_i2c_master.stop();
        apb(1'b1, isi_pkg::ADDR_MODE, 32'hC0);
        i_isi_i2c_master.start();
        i_isi_i2c_master.write_byte(8'hA4, a);
        chk(32'(a), 32'h1);
        i_isi_i2c_master.stop();
        chk(32'(n_irq), 32'h0);
        $display("test other done");
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_rx();
        t_tx();
        t_other();
        chk(32'(i_isi_i2c_master.n_stall), 32'h0);
        finish_test();
    end

    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
endmodule

`default_nettype wire
